/* File: verilog/sensor_fifo_packet_framer.sv */
// sensor_fifo_packet_framer: frames sensor samples into byte packets in a FIFO
// assumes: all inputs synchronous to clock; one sample strobe per output sample
`timescale 1ns/1ps
`include "framer_params.svh"
module sensor_fifo_packet_framer
  import framer_pkg::*;
#(
  parameter int DEF_BYTES = `FR_DEF_BYTES,
  parameter int MAX_BYTES = `FR_MAX_BYTES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        accel_en,
  input  wire logic        gyro_en,
  input  wire logic        temp_en,
  input  wire logic        frame_sync_input_en,
  input  wire logic        high_resolution_flag,
  input  wire logic        ext_zero_en,
  input  wire logic        ext_one_en,
  input  wire logic        ext_zero_nine,
  input  wire logic        extend_fifo,
  input  wire logic        motion_funcs_off,
  input  wire logic [1:0]  comp_ratio,
  input  wire logic [3:0]  fifo_decimation_rate,
  input  wire logic [3:0]  gyro_fsr,
  input  wire logic [2:0]  accel_fsr,
  input  wire logic        sample_valid,
  input  wire axes20_t     accel,
  input  wire axes20_t     gyro,
  input  wire logic [15:0] temp,
  input  wire logic [15:0] timestamp,
  input  wire logic        frame_sync_input,
  input  wire logic [15:0] frame_sync_input_delay,
  input  wire logic [3:0]  accel_rate,
  input  wire logic [3:0]  gyro_rate,
  input  wire logic [71:0] ext_zero_data,
  input  wire logic        ext_zero_valid,
  input  wire logic [71:0] ext_one_data,
  input  wire logic        ext_one_valid,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic      [13:0] byte_count,
  output logic             busy,
  output logic             drop_pulse
);
  localparam int CNT_W = 14;

  generate
    if (DEF_BYTES > MAX_BYTES || MAX_BYTES >= (1 << CNT_W) || DEF_BYTES < 32) begin : g_bad
      $error("framer: storage sizes out of range");
    end
  endgenerate

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  emit_state_t      state_q;
  logic [255:0]     pkt_q;
  logic [5:0]       len_q;
  logic [5:0]       idx_q;
  logic             frame_sync_input_seen_q;
  logic [3:0]       a_last_q;
  logic [3:0]       g_last_q;
  logic             a_seen_q;
  logic             g_seen_q;
  logic [14:0]      dec_cnt_q;
  axes16_t          prev_q;
  logic             ref_q;
  logic             drop_q;

  fifo_port_if #(.CNT_W(CNT_W)) fifo_port ();

  byte_fifo #(
    .MAX_BYTES (MAX_BYTES),
    .CNT_W     (CNT_W)
  ) u_store (
    .clock    (clock),
    .reset    (reset),
    .port     (fifo_port),
    .rd_en    (rd_en),
    .rd_data  (rd_data),
    .rd_valid (rd_valid)
  );

  // -----------------------------------------------------------------
  // data shaping
  // -----------------------------------------------------------------
  axes16_t        norm16;
  logic [47:0]    a48;
  logic [47:0]    g48;
  logic [47:0]    ah48;
  logic [47:0]    gh48;
  logic [23:0]    lo24;
  logic [2:0][19:0] a_hr;
  logic [2:0][19:0] g_hr;

  // full-scale code 0 is the narrowest range; each step halves the counts
  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign a_hr[i] = 20'($signed(accel[i]) >>> accel_fsr) & `FR_ACCEL_LSB_MASK;
    assign g_hr[i] = 20'($signed(gyro[i]) >>> gyro_fsr);
    assign norm16[i]     = accel[i][19:4];
    assign norm16[i + 3] = gyro[i][19:4];
    assign a48[47-16*i -: 16]  = accel[i][19:4];
    assign g48[47-16*i -: 16]  = gyro[i][19:4];
    assign ah48[47-16*i -: 16] = a_hr[i][19:4];
    assign gh48[47-16*i -: 16] = g_hr[i][19:4];
    assign lo24[23-8*i -: 8]   = {a_hr[i][3:0], g_hr[i][3:0]};
  end

  // -----------------------------------------------------------------
  // format selection
  // -----------------------------------------------------------------
  wire        any_int   = accel_en | gyro_en | high_resolution_flag;
  wire        any_ext   = ext_zero_en | ext_one_en;
  wire        any_sens  = any_int | any_ext;
  frame_fmt_t fmt;

  assign fmt = (any_int && any_ext)    ? FMT_MIXED :
               high_resolution_flag                ? FMT_HIRES :
               (ext_zero_en && ext_one_en) ? FMT_EXT_TWO :
               any_ext                 ? FMT_EXT_ONE :
               (accel_en && gyro_en)   ? FMT_DUAL :
               (accel_en || gyro_en)   ? FMT_SINGLE :
               FMT_NONE;

  // -----------------------------------------------------------------
  // compression
  // -----------------------------------------------------------------
  logic        fits;
  logic [47:0] packed_deltas;

  delta_packer u_pack (
    .ratio         (comp_ratio),
    .cur           (norm16),
    .prev          (prev_q),
    .fits          (fits),
    .packed_deltas (packed_deltas)
  );

  // a full frame is stored first so the host always has a reference
  wire cmp_use = (fmt == FMT_DUAL) && (comp_ratio != 2'd0) && ref_q && fits;

  // -----------------------------------------------------------------
  // header fields
  // -----------------------------------------------------------------
  wire acc_in   = accel_en | high_resolution_flag;
  wire gyr_in   = gyro_en | high_resolution_flag;
  wire time_in  = !cmp_use &&
                  (fmt == FMT_DUAL || fmt == FMT_HIRES || fmt == FMT_MIXED);
  wire fs_tag   = time_in && frame_sync_input_en && frame_sync_input_seen_q;
  wire ext_hdr  = cmp_use || fmt == FMT_EXT_ONE || fmt == FMT_EXT_TWO || fmt == FMT_MIXED;
  logic [7:0]  hdr1;
  logic [7:0]  hdr2;
  logic [7:0]  t8;
  logic [15:0] t16;
  logic [15:0] ts16;
  logic [71:0] e0_72;
  logic [71:0] e_sel72;

  always_comb begin
    hdr1 = 8'h00;
    hdr1[`FR_HB_EXT]   = ext_hdr;
    hdr1[`FR_HB_ACC]   = acc_in;
    hdr1[`FR_HB_GYR]   = gyr_in;
    hdr1[`FR_HB_HIRES] = (fmt == FMT_HIRES);
    hdr1[`FR_HB_TIME]  = time_in;
    hdr1[`FR_HB_FRAME_SYNC_INPUT] = fs_tag;
    hdr1[`FR_HB_ARATE] = acc_in && a_seen_q && (accel_rate != a_last_q);
    hdr1[`FR_HB_GRATE] = gyr_in && g_seen_q && (gyro_rate != g_last_q);
  end

  always_comb begin
    hdr2 = 8'h00;
    if (cmp_use) begin
      hdr2[`FR_H2_CMP_LSB +: 2] = comp_ratio;
    end else begin
      hdr2[`FR_H2_NINE] = ext_zero_nine;
      hdr2[`FR_H2_VAL1] = ext_one_en && ext_one_valid;
      hdr2[`FR_H2_VAL0] = ext_zero_en && ext_zero_valid;
      hdr2[`FR_H2_EN1]  = ext_one_en;
      hdr2[`FR_H2_EN0]  = ext_zero_en;
    end
  end

  assign t8      = temp_en ? temp[15:8] : 8'h00;
  assign t16     = temp_en ? temp : 16'h0000;
  assign ts16    = fs_tag ? frame_sync_input_delay : timestamp;
  assign e0_72   = ext_zero_nine ? ext_zero_data : {ext_zero_data[71:24], 24'h000000};
  assign e_sel72 = ext_zero_en ? e0_72 : ext_one_data;

  // -----------------------------------------------------------------
  // packet assembly, left aligned, header first, big endian
  // -----------------------------------------------------------------
  logic [255:0] pkt_d;
  logic [5:0]   len_d;

  always_comb begin
    pkt_d = 256'h0;
    len_d = `FR_LEN_SINGLE;
    unique case (fmt)
      FMT_NONE: begin
        pkt_d = 256'h0;
      end
      FMT_SINGLE: begin
        pkt_d = {hdr1, (accel_en ? a48 : g48), t8, 192'h0};
        len_d = `FR_LEN_SINGLE;
      end
      FMT_DUAL: begin
        if (cmp_use) begin
          pkt_d = {hdr1, hdr2, packed_deltas, t8, 184'h0};
          len_d = (comp_ratio == 2'd1) ? `FR_LEN_CMP_X2 :
                  (comp_ratio == 2'd2) ? `FR_LEN_CMP_X3 : `FR_LEN_CMP_X4;
        end else begin
          pkt_d = {hdr1, a48, g48, t8, ts16, 128'h0};
          len_d = `FR_LEN_DUAL;
        end
      end
      FMT_HIRES: begin
        pkt_d = {hdr1, ah48, gh48, t16, ts16, lo24, 96'h0};
        len_d = `FR_LEN_HIRES;
      end
      FMT_EXT_ONE: begin
        pkt_d = {hdr1, hdr2, e_sel72, 168'h0};
        len_d = `FR_LEN_EXT_ONE;
      end
      FMT_EXT_TWO: begin
        pkt_d = {hdr1, hdr2, e0_72, ext_one_data, 96'h0};
        len_d = `FR_LEN_EXT_TWO;
      end
      FMT_MIXED: begin
        // second external slot is six bytes here to fit the 32-byte frame
        pkt_d = {hdr1, hdr2, a48, g48, e0_72, ext_one_data[71:24], t8, ts16};
        len_d = `FR_LEN_MIXED;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // capacity, decimation and acceptance
  // -----------------------------------------------------------------
  wire [CNT_W-1:0] cap   = (extend_fifo && motion_funcs_off) ? CNT_W'(MAX_BYTES) :
                                                              CNT_W'(DEF_BYTES);
  wire [CNT_W-1:0] cnt   = fifo_port.count;
  wire [CNT_W-1:0] space = (cnt >= cap) ? '0 : cap - cnt;
  wire [14:0]      dec_mask = 15'((16'h0001 << fifo_decimation_rate) - 16'h0001);
  wire             dec_hit  = (dec_cnt_q & dec_mask) == 15'h0000;
  wire             want     = sample_valid && (fmt != FMT_NONE) && dec_hit;
  wire             room     = space >= CNT_W'(len_d);
  wire             accept   = want && (state_q == ST_IDLE) && room;
  wire             last_b   = (idx_q == len_q - 6'd1);

  assign fifo_port.push  = (state_q == ST_EMIT);
  assign fifo_port.wdata = pkt_q[255 - {idx_q, 3'b000} -: 8];
  assign byte_count      = cnt;
  assign busy            = (state_q == ST_EMIT);
  assign drop_pulse      = drop_q;

  // -----------------------------------------------------------------
  // emitter
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      pkt_q   <= 256'h0;
      len_q   <= 6'd0;
      idx_q   <= 6'd0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            pkt_q   <= pkt_d;
            len_q   <= len_d;
            idx_q   <= 6'd0;
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          idx_q <= idx_q + 6'd1;
          if (last_b) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // decimation counter
  // -----------------------------------------------------------------
  // the count restarts while every sensor is off, where the rate is changed
  always_ff @(posedge clock) begin
    if (reset || !any_sens) begin
      dec_cnt_q <= 15'h0000;
    end else if (sample_valid && fmt != FMT_NONE) begin
      dec_cnt_q <= dec_cnt_q + 15'h0001;
    end
  end

  // -----------------------------------------------------------------
  // header history
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      a_last_q <= 4'h0;
      g_last_q <= 4'h0;
      a_seen_q <= 1'b0;
      g_seen_q <= 1'b0;
    end else if (accept) begin
      if (acc_in) begin
        a_last_q <= accel_rate;
        a_seen_q <= 1'b1;
      end
      if (gyr_in) begin
        g_last_q <= gyro_rate;
        g_seen_q <= 1'b1;
      end
    end
  end

  // a new frame sync in the cycle of the tagging packet wins over the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      frame_sync_input_seen_q <= 1'b0;
    end else if (frame_sync_input && frame_sync_input_en) begin
      frame_sync_input_seen_q <= 1'b1;
    end else if (accept && fs_tag) begin
      frame_sync_input_seen_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // compression reference
  // -----------------------------------------------------------------
  // the host rebuilds every stored dual sample, so each one becomes the next base
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_q <= '0;
      ref_q  <= 1'b0;
    end else if (fmt != FMT_DUAL || comp_ratio == 2'd0) begin
      ref_q <= 1'b0;
    end else if (accept) begin
      prev_q <= norm16;
      ref_q  <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // drop report: sample lost to a busy emitter or a full store
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= want && !accept;
    end
  end
endmodule // sensor_fifo_packet_framer

/* File: common/framer_params.svh */
// framer_params.svh: offsets, field positions, lengths and sizes of the packet framer
// assumes: included by bare name from framer modules only
`ifndef FRAMER_PARAMS_SVH
`define FRAMER_PARAMS_SVH
// -----------------------------------------------------------------
// storage sizes in bytes
// -----------------------------------------------------------------
`define FR_DEF_BYTES 2048
`define FR_MAX_BYTES 8192
// -----------------------------------------------------------------
// packet lengths in bytes
// -----------------------------------------------------------------
`define FR_LEN_SINGLE 6'd8
`define FR_LEN_DUAL 6'd16
`define FR_LEN_HIRES 6'd20
`define FR_LEN_EXT_ONE 6'd16
`define FR_LEN_EXT_TWO 6'd20
`define FR_LEN_MIXED 6'd32
`define FR_LEN_CMP_X2 6'd9
`define FR_LEN_CMP_X3 6'd7
`define FR_LEN_CMP_X4 6'd6
// -----------------------------------------------------------------
// first header byte
// -----------------------------------------------------------------
`define FR_HB_EXT 7
`define FR_HB_ACC 6
`define FR_HB_GYR 5
`define FR_HB_HIRES 4
`define FR_HB_TIME 3
`define FR_HB_FRAME_SYNC_INPUT 2
`define FR_HB_ARATE 1
`define FR_HB_GRATE 0
// -----------------------------------------------------------------
// second header byte
// -----------------------------------------------------------------
`define FR_H2_CMP_LSB 6
`define FR_H2_NINE 4
`define FR_H2_VAL1 3
`define FR_H2_VAL0 2
`define FR_H2_EN1 1
`define FR_H2_EN0 0
// -----------------------------------------------------------------
// data shaping
// -----------------------------------------------------------------
`define FR_ACCEL_LSB_MASK 20'hffffe
`define FR_GYRO_FSR_MAX 4'h8
`define FR_ACCEL_FSR_MAX 3'h4
`endif

/* File: common/framer_pkg.sv */
// framer_pkg: types shared by the packet framer modules
// assumes: nothing beyond a SystemVerilog compiler
package framer_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EMIT = 2'b10
  } emit_state_t;
  typedef enum logic [6:0] {
    FMT_NONE    = 7'b0000001,
    FMT_SINGLE  = 7'b0000010,
    FMT_DUAL    = 7'b0000100,
    FMT_HIRES   = 7'b0001000,
    FMT_EXT_ONE = 7'b0010000,
    FMT_EXT_TWO = 7'b0100000,
    FMT_MIXED   = 7'b1000000
  } frame_fmt_t;
  typedef logic [2:0][19:0] axes20_t;
  typedef logic [5:0][15:0] axes16_t;
endpackage

/* File: common/fifo_port_if.sv */
// fifo_port_if: byte write port and fill level between framer and byte store
// assumes: one writer and one store on the same clock
`timescale 1ns/1ps
interface fifo_port_if #(parameter int CNT_W = 14);
  logic             push;
  logic [7:0]       wdata;
  logic [CNT_W-1:0] count;
  modport store (input push, input wdata, output count);
  modport feed  (output push, output wdata, input count);
endinterface

/* File: verilog/byte_fifo.sv */
// byte_fifo: flip-flop byte store with fill counter and host read port
// assumes: writer never pushes into a full store; synchronous reset
`timescale 1ns/1ps
module byte_fifo
  import framer_pkg::*;
#(
  parameter int MAX_BYTES = 8192,
  parameter int CNT_W     = 14
) (
  input  wire logic       clock,
  input  wire logic       reset,
  fifo_port_if.store      port,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  output logic            rd_valid
);
  localparam int PTR_W = $clog2(MAX_BYTES);
  logic [7:0]       mem_q [MAX_BYTES];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  wire              pop = rd_en && (count_q != '0);
  generate
    if ((1 << PTR_W) != MAX_BYTES) begin : g_bad
      $error("byte_fifo: MAX_BYTES must be a power of two");
    end
  endgenerate
  assign port.count = count_q;
  always_ff @(posedge clock) begin
    if (port.push) mem_q[wr_ptr_q] <= port.wdata;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PTR_W'(port.push);
      rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
      count_q  <= count_q + CNT_W'(port.push) - CNT_W'(pop);
      rd_valid <= pop;
      if (pop) rd_data <= mem_q[rd_ptr_q];
    end
  end
endmodule // byte_fifo

/* File: verilog/delta_packer.sv */
// delta_packer: per-axis difference check and packing for lossless compression
// assumes: ratio 1..3 means x2..x4; result is combinational
`timescale 1ns/1ps
module delta_packer
  import framer_pkg::*;
(
  input  wire logic [1:0]  ratio,
  input  wire axes16_t     cur,
  input  wire axes16_t     prev,
  output logic             fits,
  output logic      [47:0] packed_deltas
);
  logic [5:0]        fit8;
  logic [5:0]        fit5;
  logic [5:0]        fit4;
  logic [5:0][15:0]  delta;
  logic [47:0]       p8;
  logic [29:0]       p5;
  logic [23:0]       p4;
  // an axis fits when its difference sign-extends from the packed width
  for (genvar i = 0; i < 6; i++) begin : g_axis
    assign delta[i] = cur[i] - prev[i];
    assign fit8[i]  = &delta[i][15:7] || ~|delta[i][15:7];
    assign fit5[i]  = &delta[i][15:4] || ~|delta[i][15:4];
    assign fit4[i]  = &delta[i][15:3] || ~|delta[i][15:3];
    assign p8[47-8*i -: 8] = delta[i][7:0];
    assign p5[29-5*i -: 5] = delta[i][4:0];
    assign p4[23-4*i -: 4] = delta[i][3:0];
  end
  assign fits = (ratio == 2'd1) ? &fit8 :
                (ratio == 2'd2) ? &fit5 :
                (ratio == 2'd3) ? &fit4 : 1'b0;
  assign packed_deltas = (ratio == 2'd1) ? p8 :
                         (ratio == 2'd2) ? {p5, 2'b00, 16'h0000} :
                         {p4, 24'h000000};
endmodule // delta_packer

/* File: dv/host_reader.sv */
// host_reader: host side that pops framer bytes into a queue
// assumes: request changes just after the rising edge
`timescale 1ns/1ps
module host_reader (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       drain,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            rd_en
);
  logic [13:0] got[$];
  initial rd_en = 1'b0;
  // keeps asking while draining; an empty store simply refuses
  always @(posedge clock) begin
    rd_en <= drain && !reset;
    if (rd_valid) got.push_back({6'h0, rd_data});
  end
endmodule // host_reader

/* File: dv/framer_checker.sv */
// framer_checker: port assertions for the packet framer
// assumes: bound to the framer top; one clock, sync reset
`timescale 1ns/1ps
module framer_checker
  import framer_pkg::*;
#(
  parameter int DEF_BYTES = 2048,
  parameter int MAX_BYTES = 8192
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        accel_en,
  input wire logic [3:0]  fifo_decimation_rate,
  input wire logic        sample_valid,
  input wire logic        rd_en,
  input wire logic        rd_valid,
  input wire logic [13:0] byte_count,
  input wire logic        busy,
  input wire logic        drop_pulse
);
  logic [5:0] run_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // busy run length, read back at the fall
  always_ff @(posedge clock) run_q <= (reset || !busy) ? 6'h0 : run_q + 6'h1;
  chk_busy_cause: assert property ($rose(busy) |-> $past(sample_valid))
    else $error("busy without sample");
  chk_empty_read: assert property (rd_en && byte_count == 14'h0 |=> !rd_valid)
    else $error("read answered while empty");
  chk_read_pop: assert property (rd_en && byte_count != 14'h0 && !busy |=>
    rd_valid && byte_count == $past(byte_count) - 14'h1) else $error("pop count");
  chk_write_grow: assert property (busy && !rd_en |=>
    byte_count == $past(byte_count) + 14'h1) else $error("push count");
  chk_packet_len: assert property ($fell(busy) |->
    run_q inside {6'd6, 6'd7, 6'd8, 6'd9, 6'd16, 6'd20, 6'd32}) else $error("bad length");
  chk_drop_busy: assert property (sample_valid && $rose(busy) && accel_en &&
    fifo_decimation_rate == 4'h0 |=> drop_pulse) else $error("busy sample kept");
  chk_drop_cause: assert property (drop_pulse |-> $past(sample_valid))
    else $error("drop without sample");
  chk_count_cap: assert property (byte_count <= MAX_BYTES)
    else $error("count above size");
endmodule // framer_checker

bind sensor_fifo_packet_framer framer_checker #(.DEF_BYTES(DEF_BYTES), .MAX_BYTES(MAX_BYTES))
  chk_u (.clock, .reset, .accel_en, .fifo_decimation_rate, .sample_valid, .rd_en,
    .rd_valid, .byte_count, .busy, .drop_pulse);

/* File: dv/testbench.sv */
// testbench: directed framer packets drained by host_reader
// assumes: 50 MHz clock, reset held 16 cycles
`timescale 1ns/1ps
module testbench;
  import framer_pkg::*;
  logic        clock, reset, accel_en, gyro_en, temp_en, frame_sync_input_en, high_resolution_flag;
  logic        ext_zero_en, ext_one_en, ext_zero_nine, extend_fifo, motion_funcs_off;
  logic        sample_valid, frame_sync_input, ext_zero_valid, ext_one_valid, seen;
  logic        rd_en, rd_valid, busy, drop_pulse, drain;
  logic [1:0]  comp_ratio;
  logic [2:0]  accel_fsr;
  logic [3:0]  fifo_decimation_rate, gyro_fsr, accel_rate, gyro_rate;
  logic [7:0]  rd_data;
  logic [13:0] byte_count;
  logic [15:0] temp, timestamp, frame_sync_input_delay;
  logic [71:0] ext_zero_data, ext_one_data;
  axes20_t     accel, gyro;
  int          fail_count = 0, checks = 0, cyc = 0;
  int          lens[4] = '{0, 25, 23, 22};
  int          dlt[4] = '{0, 1, 8, 16};
  sensor_fifo_packet_framer dut_u (
    .clock, .reset, .accel_en, .gyro_en, .temp_en, .frame_sync_input_en, .high_resolution_flag, .ext_zero_en,
    .ext_one_en, .ext_zero_nine, .extend_fifo, .motion_funcs_off, .comp_ratio,
    .fifo_decimation_rate, .gyro_fsr, .accel_fsr, .sample_valid, .accel, .gyro, .temp,
    .timestamp, .frame_sync_input, .frame_sync_input_delay, .accel_rate, .gyro_rate, .ext_zero_data,
    .ext_zero_valid, .ext_one_data, .ext_one_valid, .rd_en, .rd_data, .rd_valid,
    .byte_count, .busy, .drop_pulse);
  host_reader host_u (.clock, .reset, .drain, .rd_data, .rd_valid, .rd_en);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic eq(input logic [13:0] got, input logic [13:0] exp);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // sets the enables, holds the strobe n cycles, waits for busy to clear
  task automatic send(input logic [4:0] en, input int n);
    @(negedge clock);
    {accel_en, gyro_en, high_resolution_flag, ext_zero_en, ext_one_en} = en;
    sample_valid = (n != 0);
    repeat (n) begin
      @(negedge clock);
      seen |= drop_pulse;
    end
    sample_valid = 1'b0;
    for (int i = 0; i < 40 && (busy || i < 3); i++) @(negedge clock);
    @(negedge clock);
  endtask
  task automatic take(input int n);
    eq(byte_count, 14'(n));
    host_u.got.delete();
    drain = 1'b1;
    for (int i = 0; i < n + 40 && host_u.got.size() < n; i++) @(negedge clock);
    drain = 1'b0;
    repeat (3) @(negedge clock);
    eq(byte_count, 14'h0);
  endtask
  initial begin
    {accel_en, gyro_en, frame_sync_input_en, high_resolution_flag, ext_zero_en, ext_one_en} = 6'h0;
    {ext_zero_nine, extend_fifo, motion_funcs_off, sample_valid, frame_sync_input} = 5'h0;
    {ext_zero_valid, ext_one_valid, drain, seen, comp_ratio} = 6'h0;
    {fifo_decimation_rate, gyro_fsr, accel_fsr, accel_rate, gyro_rate} = 19'h0;
    temp_en = 1'b1;
    accel = {20'h00c00, 20'h00b00, 20'h12345};
    gyro = {20'h00600, 20'h00500, 20'h0abcd};
    {temp, timestamp, frame_sync_input_delay} = 48'h1a2b_3c4d_5e6f;
    ext_zero_data = {8'h91, 64'h0};
    ext_one_data = {8'h82, 64'h0};
    reset = 1'b1;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    send(5'h10, 1);
    take(8);
    eq(host_u.got[0], 14'h40);
    eq(host_u.got[1], 14'h12);
    eq(host_u.got[7], 14'h1a);
    send(5'h18, 1);
    take(16);
    eq(host_u.got[0], 14'h68);
    eq(host_u.got[14], 14'h3c);
    {frame_sync_input_en, frame_sync_input, accel_rate} = 6'h33;
    gyro_rate = 4'h1;
    @(negedge clock);
    frame_sync_input = 1'b0;
    send(5'h18, 1);
    take(16);
    eq(host_u.got[0], 14'h6f);
    eq(host_u.got[14], 14'h5e);
    frame_sync_input_en = 1'b0;
    // second sample of each pair moves accel x by one count
    for (int r = 1; r < 4; r++) begin
      comp_ratio = 2'h0;
      accel[0] = 20'h12345;
      @(negedge clock);
      comp_ratio = 2'(r);
      send(5'h18, 1);
      accel[0] = 20'h12355;
      send(5'h18, 1);
      take(lens[r]);
      eq(host_u.got[16], 14'he0);
      eq(host_u.got[17], {6'h0, 2'(r), 6'h0});
      eq(host_u.got[18], 14'(dlt[r]));
    end
    accel[0] = 20'h12345;
    comp_ratio = 2'h0;
    gyro_fsr = 4'h1;
    send(5'h1c, 1);
    take(20);
    eq(host_u.got[0], 14'h78);
    eq(host_u.got[8], 14'h5e);
    eq(host_u.got[17], 14'h46);
    {ext_zero_nine, ext_zero_valid} = 2'h3;
    send(5'h02, 1);
    take(16);
    eq(host_u.got[0], 14'h80);
    eq(host_u.got[1], 14'h15);
    eq(host_u.got[2], 14'h91);
    send(5'h03, 1);
    take(20);
    eq(host_u.got[1], 14'h17);
    eq(host_u.got[11], 14'h82);
    {ext_zero_nine, ext_one_valid} = 2'h1;
    send(5'h11, 1);
    take(32);
    eq(host_u.got[0], 14'hc8);
    eq(host_u.got[1], 14'h0a);
    send(5'h00, 0);
    {fifo_decimation_rate, extend_fifo, motion_funcs_off} = 6'h7;
    temp_en = 1'b0;
    repeat (4) send(5'h10, 1);
    take(16);
    eq(host_u.got[7], 14'h00);
    eq(host_u.got[8], 14'h40);
    send(5'h00, 0);
    fifo_decimation_rate = 4'h0;
    send(5'h10, 3);
    eq({13'h0, seen}, 14'h1);
    take(8);
    // default size: 64 frames of 32 fill it, the next one is refused
    {seen, extend_fifo, motion_funcs_off} = 3'h0;
    repeat (65) send(5'h11, 1);
    eq({13'h0, seen}, 14'h1);
    eq(byte_count, 14'h800);
    {extend_fifo, motion_funcs_off} = 2'h3;
    send(5'h11, 1);
    take(2080);
    stop_test();
  end
endmodule // testbench
